//--- fsc_special_case.sv
/*
  Special-case and exception stage of a single-precision floating-point
  datapath, with a small register port and one interrupt line.
  Assumes the surrounding core supplies, in the same cycle as the
  operands, its rounded raw result: sign, biased exponent in the target
  format, fraction, an exact-zero mark, a rounding-inexact mark, and the
  integer result with its overflow mark.
*/
// How it works
// - A denormal input is treated as a zero of its own sign, giving the zero-input result and flags.
// - In IEEE mode a rounded result below 2^-126 leaves as a zero of its sign, never a denormal.
// - In IEEE mode any overflow leaves as an infinity of its sign, whatever the rounding mode.
// - A control bit picks affine or projective handling of infinities.
// - No trap is ever taken; conditions show on the flags and in sticky status bits that can raise irq_o.
// - Flags are not sticky and are recomputed for every operation.
// - In IEEE mode a nonzero rounded magnitude below 2^-126 raises underflow and inexact.
// - The alternate format holds sign in bit 31, exponent in 30..23 and mantissa in 22..0.
// - Alternate-format integer overflow gives the reserved operand and the invalid flag.
// - Alternate-format underflow gives all zeros with underflow, inexact and zero flags.
// - Alternate-format overflow gives the reserved operand with overflow, inexact and nan.
// - An alternate-format reserved input passes through, the first port winning over the second.
// - Inexact follows the core's rounding mark and is forced on overflow and underflow; a flushed denormal input never sets it.
// - In the alternate format nothing faults; six flags report everything.
// - The zero flag follows a zero result, and an alternate zero is all zero bits.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_cfg.svh"

module fsc_special_case (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Format pin, high selects IEEE mode
  input wire logic format_select_pin_i,
  // Operation request
  input wire logic op_valid_i,
  input wire fsc_pkg::fsc_op_e op_code_i,
  input wire logic [31:0] operand_a_i,
  input wire logic [31:0] operand_b_i,
  // Raw rounded result from the core
  input wire logic raw_sign_i,
  input wire logic signed [9:0] raw_exp_i,
  input wire logic [22:0] raw_mant_i,
  input wire logic raw_zero_i,
  input wire logic raw_inexact_i,
  input wire logic [31:0] raw_int_i,
  input wire logic raw_int_ovf_i,
  // Final result and flags
  output logic result_valid_o,
  output logic [31:0] result_o,
  output fsc_pkg::fsc_flags_t flags_o,
  // Register port
  input wire logic [`FSC_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Interrupt
  output logic irq_o
);
  import fsc_pkg::*;

  logic fmt_meta_reg;
  logic fmt_sync_reg;
  logic alt;
  logic proj_reg;
  fsc_flags_t irq_status_reg;
  fsc_flags_t irq_status_next;
  fsc_flags_t irq_mask_reg;
  logic irq_reg;
  logic [31:0] rdata_reg;
  logic valid_reg;
  logic [31:0] result_reg;
  fsc_flags_t flags_reg;
  logic [31:0] res_next;
  fsc_flags_t flg_next;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  logic [31:0] opnd [2];
  logic [31:0] fl [2];
  logic [1:0] zero_c;
  logic [1:0] inf_c;
  logic [1:0] nan_c;
  logic [1:0] snan_c;
  logic [1:0] rsv_c;

  assign opnd[0] = operand_a_i;
  assign opnd[1] = operand_b_i;
  assign alt = !fmt_sync_reg;
  // One decode per write target, shared by the update processes
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `FSC_ADDR_CTRL);
  assign wr_status = reg_wr_i && (reg_addr_i == `FSC_ADDR_IRQ_STATUS);
  assign wr_mask = reg_wr_i && (reg_addr_i == `FSC_ADDR_IRQ_MASK);

  // One classifier per input port
  for (genvar i = 0; i < 2; i++) begin : g_cls
    fsc_operand_class u_cls (
      .word_i(opnd[i]),
      .alt_mode_i(alt),
      .flushed_o(fl[i]),
      .is_zero_o(zero_c[i]),
      .is_inf_o(inf_c[i]),
      .is_nan_o(nan_c[i]),
      .is_snan_o(snan_c[i]),
      .is_rsv_o(rsv_c[i])
    );
  end

  // Format pin comes from off-chip
  // Resets to IEEE; a new level takes two enabled edges
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fmt_meta_reg <= 1'b1;
      fmt_sync_reg <= 1'b1;
    end else if (ce_i) begin
      fmt_meta_reg <= format_select_pin_i;
      fmt_sync_reg <= fmt_meta_reg;
    end
  end

  function automatic logic is_ieee_nan(input logic [31:0] w);
    is_ieee_nan = (w[`FSC_EXP_HI:`FSC_EXP_LO] == `FSC_IEEE_INF_EXP) &&
                  (w[`FSC_MANT_HI:0] != 23'h000000);
  endfunction

  function automatic logic [31:0] ieee_inf(input logic s);
    ieee_inf = {s, `FSC_IEEE_INF_EXP, 23'h000000};
  endfunction

  function automatic logic [31:0] ieee_zero(input logic s);
    ieee_zero = {s, 31'h00000000};
  endfunction

  // Result and flag evaluation
  always_comb begin
    logic use_a;
    logic sb_eff;
    logic raw_path;
    logic is_float;
    logic signed [9:0] ovf_lim;
    logic sp;
    res_next = {raw_sign_i, raw_exp_i[7:0], raw_mant_i};
    flg_next = '0;
    use_a = (op_code_i != FSC_OP_TWO_MINUS);
    sb_eff = fl[1][`FSC_SIGN_BIT] ^ (op_code_i == FSC_OP_SUB);
    sp = fl[0][`FSC_SIGN_BIT] ^ fl[1][`FSC_SIGN_BIT];
    raw_path = 1'b0;
    is_float = (op_code_i != FSC_OP_F2I);
    ovf_lim = alt ? `FSC_EXP_OVF_ALT : `FSC_EXP_OVF_IEEE;
    if (op_code_i == FSC_OP_F2I) begin
      if (alt && rsv_c[0]) begin
        res_next = operand_a_i;
        flg_next[`FSC_FLG_INVALID] = 1'b1;
        flg_next[`FSC_FLG_NAN] = 1'b1;
      end else if (!alt && (nan_c[0] || inf_c[0])) begin
        res_next = `FSC_RSV_OPERAND;
        flg_next[`FSC_FLG_INVALID] = 1'b1;
      end else if (zero_c[0]) begin
        res_next = 32'h00000000;
      end else if (raw_int_ovf_i) begin
        res_next = `FSC_RSV_OPERAND;
        flg_next[`FSC_FLG_INVALID] = 1'b1;
        flg_next[`FSC_FLG_NAN] = alt;
      end else begin
        res_next = raw_int_i;
        flg_next[`FSC_FLG_INEXACT] = raw_inexact_i;
      end
    end else if (op_code_i == FSC_OP_I2F) begin
      raw_path = 1'b1;
    end else if (alt) begin
      if (use_a && rsv_c[0]) begin
        res_next = operand_a_i;
      end else if (rsv_c[1]) begin
        res_next = operand_b_i;
      end else begin
        raw_path = 1'b1;
      end
    end else if ((use_a && nan_c[0]) || nan_c[1]) begin
      res_next = (use_a && nan_c[0]) ? operand_a_i : operand_b_i;
      res_next[`FSC_QUIET_BIT] = 1'b1;
      flg_next[`FSC_FLG_INVALID] = (use_a && snan_c[0]) || snan_c[1];
    end else if (op_code_i == FSC_OP_MUL) begin
      if ((inf_c[0] && zero_c[1]) || (zero_c[0] && inf_c[1])) begin
        res_next = `FSC_DEFAULT_QNAN;
        flg_next[`FSC_FLG_INVALID] = 1'b1;
      end else if (inf_c[0] || inf_c[1]) begin
        res_next = ieee_inf(sp);
      end else if (zero_c[0] || zero_c[1]) begin
        res_next = ieee_zero(sp);
      end else begin
        raw_path = 1'b1;
      end
    end else if (op_code_i == FSC_OP_TWO_MINUS) begin
      if (inf_c[1]) begin
        // Projective infinity is unsigned; give the opposite of b's sign for ordering
        res_next = ieee_inf(!fl[1][`FSC_SIGN_BIT]);
      end else if (zero_c[1]) begin
        res_next = `FSC_TWO;
      end else begin
        raw_path = 1'b1;
      end
    end else begin
      if (inf_c[0] && inf_c[1]) begin
        if (proj_reg || (fl[0][`FSC_SIGN_BIT] != sb_eff)) begin
          res_next = `FSC_DEFAULT_QNAN;
          flg_next[`FSC_FLG_INVALID] = 1'b1;
        end else begin
          res_next = ieee_inf(sb_eff);
        end
      end else if (inf_c[0]) begin
        res_next = operand_a_i;
      end else if (inf_c[1]) begin
        res_next = ieee_inf(sb_eff);
      end else if (zero_c[0] && zero_c[1]) begin
        res_next = ieee_zero(fl[0][`FSC_SIGN_BIT] & sb_eff);
      end else if (zero_c[0]) begin
        res_next = {sb_eff, fl[1][30:0]};
      end else if (zero_c[1]) begin
        res_next = fl[0];
      end else begin
        raw_path = 1'b1;
      end
    end
    // Range checks apply only to a result that came from the core
    if (raw_path) begin
      flg_next[`FSC_FLG_INEXACT] = raw_inexact_i;
      if (raw_zero_i) begin
        res_next = alt ? `FSC_ALT_ZERO : ieee_zero(raw_sign_i);
      end else if (raw_exp_i >= ovf_lim) begin
        flg_next[`FSC_FLG_OVERFLOW] = 1'b1;
        flg_next[`FSC_FLG_INEXACT] = 1'b1;
        if (alt) begin
          res_next = `FSC_RSV_OPERAND;
        end else begin
          res_next = ieee_inf(raw_sign_i);
        end
      end else if (raw_exp_i < `FSC_EXP_MIN) begin
        flg_next[`FSC_FLG_UNDERFLOW] = 1'b1;
        flg_next[`FSC_FLG_INEXACT] = 1'b1;
        if (alt) begin
          res_next = `FSC_ALT_ZERO;
        end else begin
          res_next = ieee_zero(raw_sign_i);
        end
      end
    end
    if (is_float) begin
      if (alt) begin
        flg_next[`FSC_FLG_ZERO] = (res_next == `FSC_ALT_ZERO);
        flg_next[`FSC_FLG_NAN] = res_next[`FSC_SIGN_BIT] &&
          (res_next[`FSC_EXP_HI:`FSC_EXP_LO] == 8'h00);
      end else begin
        flg_next[`FSC_FLG_ZERO] = (res_next[30:0] == 31'h00000000);
        flg_next[`FSC_FLG_NAN] = is_ieee_nan(res_next);
      end
    end else begin
      flg_next[`FSC_FLG_ZERO] = (res_next == 32'h00000000);
    end
  end

  // Result and flags leave together, replaced on every operation
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      valid_reg <= 1'b0;
      result_reg <= 32'h00000000;
      flags_reg <= '0;
    end else if (ce_i) begin
      valid_reg <= op_valid_i;
      // Held pair stays coherent while no operation is taken
      if (op_valid_i) begin
        result_reg <= res_next;
        flags_reg <= flg_next;
      end
    end
  end

  // Software registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      proj_reg <= `FSC_CTRL_RESET;
      irq_mask_reg <= `FSC_IRQ_MASK_RESET;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        proj_reg <= reg_wdata_i[`FSC_CTRL_PROJ_BIT];
      end
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata_i[`FSC_NUM_FLAGS-1:0];
      end
    end
  end

  // Sticky event bits; a new event beats a same-cycle clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_status) begin
      irq_status_next = irq_status_next & ~reg_wdata_i[`FSC_NUM_FLAGS-1:0];
    end
    if (op_valid_i) begin
      irq_status_next = irq_status_next | flg_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_status_reg <= '0;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_status_reg <= irq_status_next;
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end

  // Read data valid the cycle after the strobe only
  // Zero otherwise, so a late sample reads as nothing
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_reg <= 32'h00000000;
    end else if (ce_i) begin
      rdata_reg <= 32'h00000000;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          `FSC_ADDR_CTRL: rdata_reg <= {31'h00000000, proj_reg};
          `FSC_ADDR_IRQ_STATUS: rdata_reg <= {26'h0000000, irq_status_reg};
          `FSC_ADDR_IRQ_MASK: rdata_reg <= {26'h0000000, irq_mask_reg};
          `FSC_ADDR_FLAGS: rdata_reg <= {25'h0000000, alt, flags_reg};
          `FSC_ADDR_RESULT: rdata_reg <= result_reg;
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  assign result_valid_o = valid_reg;
  assign result_o = result_reg;
  assign flags_o = flags_reg;
  assign reg_rdata_o = rdata_reg;
  assign irq_o = irq_reg;
endmodule // fsc_special_case

`default_nettype wire

//--- fsc_cfg.svh
/*
  Constants of the floating-point special-case stage: register offsets,
  flag bit positions, reset values, exponent limits and fixed patterns.
  Assumes it is included by its bare name after the package.
*/
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH

`define FSC_ADDR_W 5
`define FSC_ADDR_CTRL 5'h00
`define FSC_ADDR_IRQ_STATUS 5'h04
`define FSC_ADDR_IRQ_MASK 5'h08
`define FSC_ADDR_FLAGS 5'h0c
`define FSC_ADDR_RESULT 5'h10

`define FSC_CTRL_PROJ_BIT 0
`define FSC_CTRL_RESET 1'b0
`define FSC_IRQ_MASK_RESET 6'h00

`define FSC_NUM_FLAGS 6
`define FSC_FLG_INVALID 0
`define FSC_FLG_OVERFLOW 1
`define FSC_FLG_UNDERFLOW 2
`define FSC_FLG_INEXACT 3
`define FSC_FLG_ZERO 4
`define FSC_FLG_NAN 5

`define FSC_SIGN_BIT 31
`define FSC_EXP_HI 30
`define FSC_EXP_LO 23
`define FSC_MANT_HI 22
`define FSC_QUIET_BIT 22

`define FSC_EXP_OVF_IEEE 10'sh0ff
`define FSC_EXP_OVF_ALT 10'sh100
`define FSC_EXP_MIN 10'sh001

`define FSC_RSV_OPERAND 32'h8000_0000
`define FSC_ALT_ZERO 32'h0000_0000
`define FSC_DEFAULT_QNAN 32'h7fc0_0000
`define FSC_TWO 32'h4000_0000
`define FSC_IEEE_INF_EXP 8'hff

`endif

//--- fsc_pkg.sv
/*
  Types shared by the special-case stage, its assertion module and its bench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fsc_pkg;
  typedef enum logic [2:0] {
    FSC_OP_ADD,
    FSC_OP_SUB,
    FSC_OP_MUL,
    FSC_OP_TWO_MINUS,
    FSC_OP_F2I,
    FSC_OP_I2F
  } fsc_op_e;

  typedef logic [5:0] fsc_flags_t;
endpackage

//--- fsc_operand_class.sv
/*
  Combinational classifier for one 32-bit operand in either format.
  Assumes the caller states which format governs the word.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsc_cfg.svh"

module fsc_operand_class (
  // Operand and mode
  input wire logic [31:0] word_i,
  input wire logic alt_mode_i,
  // Class
  output logic [31:0] flushed_o,
  output logic is_zero_o,
  output logic is_inf_o,
  output logic is_nan_o,
  output logic is_snan_o,
  output logic is_rsv_o
);
  logic exp_zero;
  logic exp_ones;
  logic mant_zero;

  assign exp_zero = (word_i[`FSC_EXP_HI:`FSC_EXP_LO] == 8'h00);
  assign exp_ones = (word_i[`FSC_EXP_HI:`FSC_EXP_LO] == `FSC_IEEE_INF_EXP);
  assign mant_zero = (word_i[`FSC_MANT_HI:0] == 23'h000000);

  always_comb begin
    flushed_o = word_i;
    is_zero_o = 1'b0;
    is_inf_o = 1'b0;
    is_nan_o = 1'b0;
    is_snan_o = 1'b0;
    is_rsv_o = 1'b0;
    if (alt_mode_i) begin
      // Sign set with exponent zero is the reserved operand
      is_rsv_o = exp_zero && word_i[`FSC_SIGN_BIT];
      is_zero_o = exp_zero && !word_i[`FSC_SIGN_BIT];
      if (is_zero_o) begin
        flushed_o = `FSC_ALT_ZERO;
      end
    end else begin
      is_zero_o = exp_zero;
      is_inf_o = exp_ones && mant_zero;
      is_nan_o = exp_ones && !mant_zero;
      is_snan_o = is_nan_o && !word_i[`FSC_QUIET_BIT];
      if (exp_zero) begin
        // Denormal becomes a zero of the same sign
        flushed_o = {word_i[`FSC_SIGN_BIT], 31'h00000000};
      end
    end
  end
endmodule // fsc_operand_class

`default_nettype wire

//--- fsc_special_case_assertions.sv
/*
  Concurrent checks on the ports of the special-case stage.
  Assumes it is bound to fsc_special_case and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none

module fsc_special_case_assertions (
  // Clock and controls
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic format_select_pin_i,
  // Operation
  input wire logic op_valid_i,
  input wire fsc_pkg::fsc_op_e op_code_i,
  input wire logic [31:0] operand_a_i,
  input wire logic [31:0] operand_b_i,
  input wire logic raw_sign_i,
  input wire logic signed [9:0] raw_exp_i,
  input wire logic [22:0] raw_mant_i,
  input wire logic raw_zero_i,
  input wire logic raw_inexact_i,
  input wire logic raw_int_ovf_i,
  // Results
  input wire logic result_valid_o,
  input wire logic [31:0] result_o,
  input wire fsc_pkg::fsc_flags_t flags_o
);
  import fsc_pkg::*;
  logic [1:0] stab_reg;
  logic pin_reg;
  logic go;
  logic ieee;
  logic alt;
  logic norm;
  logic arith;
  // Pin passes a synchroniser, so trust it only after three steady edges
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stab_reg <= 2'h0;
      pin_reg <= 1'b1;
    end else if (ce_i) begin
      pin_reg <= format_select_pin_i;
      if (format_select_pin_i != pin_reg)
        stab_reg <= 2'h0;
      else if (stab_reg != 2'h3)
        stab_reg <= stab_reg + 2'h1;
    end
  end
  assign go = op_valid_i && ce_i && stab_reg == 2'h3 &&
    pin_reg == format_select_pin_i;
  assign ieee = go && format_select_pin_i;
  assign alt = go && !format_select_pin_i;
  assign norm = operand_a_i[30:23] != 8'h00 && operand_a_i[30:23] != 8'hff &&
    operand_b_i[30:23] != 8'h00 && operand_b_i[30:23] != 8'hff;
  assign arith = op_code_i inside {FSC_OP_ADD, FSC_OP_SUB, FSC_OP_MUL};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  valid_pulse_a: assert property (op_valid_i && ce_i |=> result_valid_o)
    else $error("result valid missing");
  output_hold_a: assert property (!(op_valid_i && ce_i) |=> !result_valid_o
    && $stable(result_o) && $stable(flags_o)) else $error("output moved");
  ieee_ovf_a: assert property (ieee && norm && arith && !raw_zero_i &&
    raw_exp_i >= 10'sh0ff |=> result_o == {$past(raw_sign_i), 31'h7f80_0000}
    && flags_o[1] && flags_o[3]) else $error("overflow not infinity");
  ieee_tiny_a: assert property (ieee && norm && arith && !raw_zero_i &&
    raw_exp_i < 10'sh001 |=> result_o == {$past(raw_sign_i), 31'h0} &&
    flags_o == 6'h1c) else $error("tiny result not flushed");
  exact_add_a: assert property (ieee && norm && op_code_i == FSC_OP_ADD &&
    !raw_zero_i && !raw_inexact_i && raw_exp_i inside {[10'sh001:10'sh0fe]}
    |=> result_o == {$past(raw_sign_i), $past(raw_exp_i[7:0]),
    $past(raw_mant_i)} && !flags_o[3]) else $error("exact result wrong");
  alt_ovf_a: assert property (alt && norm && arith && !raw_zero_i &&
    raw_exp_i >= 10'sh100 |=> result_o == 32'h8000_0000 && flags_o == 6'h2a)
    else $error("alternate overflow wrong");
  alt_tiny_a: assert property (alt && norm && arith && !raw_zero_i &&
    raw_exp_i < 10'sh001 |=> result_o == 32'h0 && flags_o == 6'h1c)
    else $error("alternate underflow wrong");
  int_ovf_a: assert property (alt && op_code_i == FSC_OP_F2I &&
    raw_int_ovf_i && operand_a_i[30:23] != 8'h00 |=>
    result_o == 32'h8000_0000 && flags_o[0]) else $error("int overflow wrong");
  rsv_pass_a: assert property (alt && arith && operand_a_i[31] &&
    operand_a_i[30:23] == 8'h00 |=> result_o == $past(operand_a_i) &&
    flags_o[5]) else $error("reserved operand lost");
  denorm_in_a: assert property (ieee && op_code_i == FSC_OP_MUL &&
    operand_a_i[30:23] == 8'h00 && operand_a_i[22:0] != 23'h0 &&
    operand_b_i[30:23] inside {[8'h01:8'hfe]} |=> result_o == {$past(
    operand_a_i[31]) ^ $past(operand_b_i[31]), 31'h0} && flags_o == 6'h10)
    else $error("denormal input not zero");

  cover property (ieee && arith && raw_exp_i >= 10'sh0ff);
  cover property (alt && arith && operand_a_i[31] && operand_a_i[30:23] == 8'h00);
  cover property (alt && op_code_i == FSC_OP_F2I && raw_int_ovf_i);
endmodule // fsc_special_case_assertions

bind fsc_special_case fsc_special_case_assertions u_chk (
  .core_clk_i, .reset_i, .ce_i, .format_select_pin_i, .op_valid_i,
  .op_code_i, .operand_a_i, .operand_b_i, .raw_sign_i, .raw_exp_i,
  .raw_mant_i, .raw_zero_i, .raw_inexact_i, .raw_int_ovf_i,
  .result_valid_o, .result_o, .flags_o
);

`default_nettype wire

//--- fsc_word_swap.sv
/*
  Far-side logic that wants minicomputer word order.
  Assumes a 32-bit alternate-format word from the stage.
*/
`timescale 1ns/100ps
`default_nettype none

module fsc_word_swap (
  // Word in stage order
  input wire logic [31:0] word_i,
  // Word in minicomputer order
  output logic [31:0] word_o
);
  assign word_o = {word_i[15:0], word_i[31:16]};
endmodule // fsc_word_swap

`default_nettype wire

//--- test_fp_special_case_handling.sv
/*
  Self-checking bench for the special-case stage.
  Assumes the package, header, stage and far-side swap are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsc_cfg.svh"

module test_fp_special_case_handling;
  import fsc_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic format_select_pin_i = 1'b1;
  logic op_valid_i = 1'b0;
  fsc_op_e op_code_i = FSC_OP_ADD;
  logic [31:0] operand_a_i = 32'h0, operand_b_i = 32'h0, raw_int_i = 32'h0;
  logic raw_sign_i = 1'b0, raw_zero_i = 1'b0, raw_inexact_i = 1'b0;
  logic raw_int_ovf_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic signed [9:0] raw_exp_i = 10'sh0;
  logic [22:0] raw_mant_i = 23'h0, rm;
  logic [31:0] ri;
  logic [4:0] reg_addr_i = 5'h0;
  logic [31:0] reg_wdata_i = 32'h0, result_o, reg_rdata_o, swap_w;
  logic result_valid_o, irq_o;
  fsc_flags_t flags_o;
  logic [37:0] exp_q[$];
  int mismatches = 0, cmp_count = 0, cycles = 0;

  fsc_special_case uut (.core_clk_i, .reset_i, .ce_i, .format_select_pin_i,
    .op_valid_i, .op_code_i, .operand_a_i, .operand_b_i, .raw_sign_i,
    .raw_exp_i, .raw_mant_i, .raw_zero_i, .raw_inexact_i, .raw_int_i,
    .raw_int_ovf_i, .result_valid_o, .result_o, .flags_o, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
  fsc_word_swap u_swap (.word_i(result_o), .word_o(swap_w));

  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic check_op(input logic [37:0] got, input logic [37:0] want);
    cmp_count++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic check_reg(input logic [31:0] got, input logic [31:0] want);
    check_op({6'h0, got}, {6'h0, want});
  endtask
  task summarize;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Leaves valid high so that calls in a row go back to back
  task automatic op(input fsc_op_e c, input logic [31:0] a, b,
    input logic s, input logic signed [9:0] e, input logic z, ix, io,
    input logic [31:0] w, input fsc_flags_t wf);
    @(posedge core_clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    operand_a_i <= a;
    operand_b_i <= b;
    raw_sign_i <= s;
    raw_exp_i <= e;
    raw_mant_i <= rm;
    raw_zero_i <= z;
    raw_inexact_i <= ix;
    raw_int_ovf_i <= io;
    raw_int_i <= ri;
    exp_q.push_back({wf, w});
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      op_valid_i <= 1'b0;
    end
  endtask
  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] ad, input logic [31:0] want);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 check_reg(reg_rdata_o, want);
  endtask

  // Result watcher; an unasked result compares against its own inverted value
  always @(negedge core_clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      summarize();
    end
    if (result_valid_o === 1'b1)
      check_op({flags_o, result_o}, exp_q.size() != 0 ? exp_q.pop_front() :
        ~{flags_o, result_o});
  end

  initial begin
    rm = 23'($urandom(58));
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(`FSC_ADDR_CTRL, 32'h0);
    rd(`FSC_ADDR_IRQ_MASK, 32'h0);
    rd(5'h1c, 32'h0);
    rm = 23'($urandom());
    ri = $urandom() | 32'h1;
    // Inexact op, then an exact one must clear the flag
    op(FSC_OP_ADD, 32'h3f80_0000, 32'h4000_0000, 0, 10'sh07f, 0, 1, 0,
      {1'b0, 8'h7f, rm}, 6'h08);
    op(FSC_OP_ADD, 32'h3f80_0000, 32'h4000_0000, 1, 10'sh080, 0, 0, 0,
      {1'b1, 8'h80, rm}, 6'h00);
    op(FSC_OP_MUL, 32'h4000_0000, 32'h4000_0000, 0, 10'sh0ff, 0, 1, 0,
      32'h7f80_0000, 6'h0a);
    op(FSC_OP_MUL, 32'hc000_0000, 32'h4000_0000, 1, 10'sh140, 0, 0, 0,
      32'hff80_0000, 6'h0a);
    op(FSC_OP_SUB, 32'h3f80_0000, 32'h4000_0000, 1, -10'sd3, 0, 1, 0,
      32'h8000_0000, 6'h1c);
    op(FSC_OP_MUL, 32'h8000_1234, 32'h4000_0000, 0, 10'sh080, 0, 0, 0,
      32'h8000_0000, 6'h10);
    op(FSC_OP_ADD, 32'h0000_0001, 32'h4040_0000, 0, 10'sh001, 0, 1, 0,
      32'h4040_0000, 6'h00);
    op(FSC_OP_ADD, 32'h7f80_0000, 32'h7f80_0000, 0, 10'sh0ff, 0, 0, 0,
      32'h7f80_0000, 6'h00);
    op(FSC_OP_ADD, 32'h3f80_0000, 32'hbf80_0000, 1, 10'sh000, 1, 0, 0,
      32'h8000_0000, 6'h10);
    op(FSC_OP_ADD, 32'h7f80_0001, 32'h3f80_0000, 0, 10'sh0ff, 0, 0, 0,
      32'h7fc0_0001, 6'h21);
    op(FSC_OP_TWO_MINUS, {9'h0, rm}, 32'h8000_0000, 0, 10'sh080, 0, 0, 0,
      32'h4000_0000, 6'h00);
    op(FSC_OP_TWO_MINUS, 32'h0, 32'hff80_0000, 0, 10'sh080, 0, 0, 0,
      32'h7f80_0000, 6'h00);
    op(FSC_OP_I2F, 32'h0, 32'h0, 1, 10'sh09d, 0, 1, 0,
      {1'b1, 8'h9d, rm}, 6'h08);
    op(FSC_OP_F2I, 32'h4f00_0000, 32'h0, 0, 10'sh09e, 0, 1, 0,
      ri, 6'h08);
    op(FSC_OP_F2I, 32'h7f80_0000, 32'h0, 0, 10'sh0ff, 0, 0, 0,
      32'h8000_0000, 6'h01);
    idle(2);
    wr(`FSC_ADDR_CTRL, 32'h1);
    op(FSC_OP_ADD, 32'h7f80_0000, 32'h7f80_0000, 0, 10'sh0ff, 0, 0, 0,
      32'h7fc0_0000, 6'h21);
    idle(2);
    wr(`FSC_ADDR_CTRL, 32'h0);
    // Sticky status, mask and level interrupt
    wr(`FSC_ADDR_IRQ_STATUS, 32'h3f);
    op(FSC_OP_SUB, 32'h3f80_0000, 32'h4000_0000, 0, -10'sd1, 0, 1, 0,
      32'h0, 6'h1c);
    idle(3);
    check_reg({31'h0, irq_o}, 32'h0);
    rd(`FSC_ADDR_IRQ_STATUS, 32'h1c);
    wr(`FSC_ADDR_IRQ_MASK, 32'h04);
    idle(2);
    check_reg({31'h0, irq_o}, 32'h1);
    wr(`FSC_ADDR_IRQ_STATUS, 32'h04);
    idle(2);
    check_reg({31'h0, irq_o}, 32'h0);
    rd(`FSC_ADDR_IRQ_STATUS, 32'h18);
    // Alternate format; synchroniser needs settled edges first
    @(posedge core_clk_i);
    format_select_pin_i <= 1'b0;
    idle(4);
    op(FSC_OP_ADD, 32'h3f80_0000, 32'h4000_0000, 0, 10'sh100, 0, 1, 0,
      32'h8000_0000, 6'h2a);
    op(FSC_OP_MUL, 32'h3f80_0000, 32'hc000_0000, 1, -10'sd5, 0, 1, 0,
      32'h0, 6'h1c);
    op(FSC_OP_F2I, 32'h5000_0000, 32'h0, 0, 10'sh0a0, 0, 0, 1,
      32'h8000_0000, 6'h21);
    op(FSC_OP_ADD, 32'h3f80_0000, 32'hbf80_0000, 1, 10'sh000, 1, 0, 0,
      32'h0, 6'h10);
    op(FSC_OP_F2I, 32'h8000_1111, 32'h0, 0, 10'sh080, 0, 0, 0,
      32'h8000_1111, 6'h21);
    op(FSC_OP_MUL, 32'h8076_5432, 32'h8000_0001, 1, 10'sh080, 0, 0, 0,
      32'h8076_5432, 6'h20);
    op(FSC_OP_ADD, 32'h4080_0000, 32'h8001_2345, 0, 10'sh081, 0, 0, 0,
      32'h8001_2345, 6'h20);
    idle(2);
    check_reg(swap_w, 32'h2345_8001);
    rd(`FSC_ADDR_FLAGS, 32'h60);
    rd(`FSC_ADDR_RESULT, 32'h8001_2345);
    // Clock enable low must drop the request
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    op_valid_i <= 1'b1;
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    op_valid_i <= 1'b0;
    idle(3);
    check_reg(32'(exp_q.size()), 32'h0);
    summarize();
  end
endmodule // test_fp_special_case_handling

`default_nettype wire
